// File: iwd_pkg.sv
// Shared constants and types for the instruction word decoder.
// Assumes a single clock domain and octal operation codes held in hex form.
package iwd_pkg;

    // ***************************************************************
    // Word and field layout
    // ***************************************************************
    localparam int WORD_W = 48;
    localparam int INS_W = 24;
    localparam int OP_W = 6;
    localparam int DES_W = 3;
    localparam int ADDR_W = 15;
    localparam int DIG_W = 3;
    localparam int UPPER_LSB = 24;
    localparam int OP_LSB = 18;
    localparam int DES_LSB = 15;
    localparam int ADDR_LSB = 0;
    localparam int CHAN_N = 6;

    // ***************************************************************
    // Code values (octal shown in comments)
    // ***************************************************************
    localparam logic [OP_W-1:0] OP_FAULT_LO = 6'h00; // 00
    localparam logic [OP_W-1:0] OP_FAULT_HI = 6'h3F; // 77
    localparam logic [OP_W-1:0] OP_NOP = 6'h28; // 50
    localparam logic [DES_W-1:0] DES_NONE = 3'h0;
    localparam logic [DES_W-1:0] DES_INDIRECT = 3'h7;
    localparam logic [DES_W-1:0] DES_SENSE = 3'h7;
    localparam logic [1:0] TST_ZERO = 2'h0;
    localparam logic [1:0] TST_NONZERO = 2'h1;
    localparam logic [1:0] TST_POS = 2'h2;
    localparam logic [1:0] TST_NEG = 2'h3;
    localparam int RET_BIT = 2;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 48'h000000000000;

    // Second-level translation groups
    typedef struct packed {
        logic fault;       // 00 or 77
        logic index_mod;   // Index added to address
        logic idx_operand; // Index joins the basic operation
        logic xfer_search; // 62-67
        logic a_jump;      // 22
        logic q_jump;      // 23
        logic io_cond;     // 74
        logic sel_jump;    // 75
        logic sel_stop;    // 76
        logic op_nop;      // 50
        logic addr_opnd;   // Address names a storage operand
    } iwd_grp_t;

    localparam iwd_grp_t GRP_RST = '0;

    // Sequencer states, Gray along fetch, copy, add, execute, shift
    typedef enum logic [2:0] {
        ST_FETCH = 3'h0,
        ST_COPY = 3'h1,
        ST_ADD = 3'h3,
        ST_EXEC = 3'h2,
        ST_SHIFT = 3'h6,
        ST_HALT = 3'h4
    } iwd_state_t;

    // One's complement sum formed subtractively: a - ~b with end-around borrow
    function automatic logic [ADDR_W-1:0] iwd_sub_add(input logic [ADDR_W-1:0] a,
                                                       input logic [ADDR_W-1:0] b);
        logic [ADDR_W-1:0] nb;
        logic [ADDR_W-1:0] d;
        logic brw;
        nb = ~b;
        brw = 1'b0;
        for (int i = 0; i < ADDR_W; i++)
        begin
            d[i] = a[i] ^ nb[i] ^ brw;
            brw = (~a[i] & (nb[i] | brw)) | (nb[i] & brw);
        end
        // End-around borrow pass
        for (int i = 0; i < ADDR_W; i++)
        begin
            nb[i] = d[i] ^ brw;
            brw = brw & ~d[i];
        end
        return nb;
    endfunction

endpackage

// File: iwd_xlat_if.sv
// Carrier between the sequencer and the operation code translator.
// Assumes both ends share the decoder clock; the bundle is combinational.
`timescale 1ns/1ns
interface iwd_xlat_if;
    logic [iwd_pkg::OP_W-1:0] op;
    logic [7:0] lo_hot;
    logic [7:0] hi_hot;
    logic [3:0] lo_grp;
    iwd_pkg::iwd_grp_t grp;

    // Translator end
    modport xlat (input op, output lo_hot, output hi_hot, output lo_grp, output grp);
    // Sequencer end
    modport user (output op, input lo_hot, input hi_hot, input lo_grp, input grp);
endinterface

// File: iwd_opxlat.sv
// Two-level operation code translator.
// Assumes the operation code comes straight from the holding rank flops.
`timescale 1ns/1ns
module iwd_opxlat (
    // Translation bundle
    iwd_xlat_if.xlat x
);
    logic [iwd_pkg::DIG_W-1:0] lo;
    logic [iwd_pkg::DIG_W-1:0] hi;
    logic [7:0] l;
    logic [7:0] h;

    // ***************************************************************
    // First level: each octal digit apart
    // ***************************************************************
    assign lo = x.op[iwd_pkg::DIG_W-1:0]; // RULE_07
    assign hi = x.op[iwd_pkg::OP_W-1:iwd_pkg::DIG_W]; // RULE_07

    // One-hot decodes of both digits
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_dig
            assign l[gi] = (lo == 3'(gi)); // RULE_08
            assign h[gi] = (hi == 3'(gi)); // RULE_09
        end
    endgenerate
    assign x.lo_hot = l;
    assign x.hi_hot = h;

    // Partial decodes of the lower digit: 0-1, 0-3, 2-7, 4-7
    assign x.lo_grp[0] = ~lo[2] & ~lo[1]; // RULE_08
    assign x.lo_grp[1] = ~lo[2];
    assign x.lo_grp[2] = lo[2] | lo[1];
    assign x.lo_grp[3] = lo[2];

    // ***************************************************************
    // Second level: unique codes and code groups
    // ***************************************************************
    always_comb
    begin
        x.grp = iwd_pkg::GRP_RST;
        x.grp.fault = (h[0] & l[0]) | (h[7] & l[7]); // RULE_10
        x.grp.index_mod = (h[0] & ~l[0]) | h[1] | (h[2] & x.lo_grp[0])
                        | (h[2] & x.lo_grp[3]) | (h[3] & x.lo_grp[1])
                        | (h[3] & (l[6] | l[7])) | h[4] | (h[7] & x.lo_grp[1]);
        x.grp.idx_operand = (h[3] & (l[4] | l[5])) | h[5] | (h[6] & x.lo_grp[2]);
        x.grp.xfer_search = h[6] & x.lo_grp[2];
        x.grp.a_jump = h[2] & l[2];
        x.grp.q_jump = h[2] & l[3];
        x.grp.io_cond = h[7] & l[4];
        x.grp.sel_jump = h[7] & l[5];
        x.grp.sel_stop = h[7] & l[6];
        x.grp.op_nop = h[5] & l[0];
        x.grp.addr_opnd = (h[1] & x.lo_grp[2]) | h[2] | (h[3] & ~(l[4] | l[5])) | h[4]
                        | (h[5] & x.lo_grp[2] & ~l[4]) | h[6]
                        | (h[7] & (x.lo_grp[1] | l[5] | l[6]));
    end
endmodule // iwd_opxlat

// File: iwd_decoder.sv
// Instruction word decoder: holding rank, translation, address accumulator.
// Assumes storage, index registers and execution units share clk; lever keys are async pins.
//
// Behaviour
// (RULE_01) Instruction is 24 bits: 6-bit code, 3-bit designator, address field.
// (RULE_02) Load 48-bit word; run upper half, then move lower half up.
// (RULE_03) Second rank is a 15-bit subtractive accumulator on the upper address.
// (RULE_04) Copy address, add selected index, send result as operand address.
// (RULE_05) Codes 00 and 77 are faults that halt; the other 62 are instructions.
// (RULE_06) Translate the upper six holding bits before execution starts.
// (RULE_07) Decode lower octal digit apart from the upper octal digit.
// (RULE_08) Lower digit gets one-hot decode plus partial group decodes.
// (RULE_09) Upper digit gets a one-hot decode.
// (RULE_10) Combine both digit decodes into unique and group signals.
// (RULE_11) Index group adds designated index; 0 unmodified, 7 indirect.
// (RULE_12) 34, 35, 50-57, 62-67 use index as operand; 7 still indirect.
// (RULE_13) Code 50 with designator 0 is a no-operation.
// (RULE_14) Transfer and search with designator 0 handle exactly one word.
// (RULE_15) Register jumps test zero, nonzero, positive, negative; 4-7 return jump.
// (RULE_16) Selective jump: 0 always, 1-3 on lever key; 4-7 return jump.
// (RULE_17) Selective stop always jumps; stop on 0 or lever key; 4-7 return.
// (RULE_18) I/O condition: 0 external equipment, 1-4 channels one to four.
// (RULE_19) I/O condition: 5 and 6 channels five, six; 7 senses external.
// (RULE_20) Base execution address is the lowest 15 instruction bits.
// (RULE_21) After both halves run, request and load the next word.
`timescale 1ns/1ns
module iwd_decoder #(
    parameter int WORD_W = iwd_pkg::WORD_W,
    parameter int ADDR_W = iwd_pkg::ADDR_W
) (
    // Clock, reset, enable
    input logic clk,
    input logic rst_n,
    input logic ce,
    // Storage word request
    output logic word_req,
    input logic word_ack,
    input logic [WORD_W-1:0] word_data,
    // Index register access
    output logic [iwd_pkg::DES_W-1:0] idx_sel,
    input logic [ADDR_W-1:0] idx_value,
    // Execution handshake
    output logic instr_valid,
    input logic exec_done,
    // Translation results
    output logic [iwd_pkg::OP_W-1:0] op_code,
    output logic [7:0] op_lo_hot,
    output logic [7:0] op_hi_hot,
    output logic [3:0] op_lo_grp,
    output iwd_pkg::iwd_grp_t op_grp,
    output logic fault_halt,
    // Address and designator results
    output logic [ADDR_W-1:0] operand_addr,
    output logic addr_valid,
    output logic indirect,
    output logic idx_operand,
    output logic one_word,
    output logic nop,
    // Condition sources
    input logic a_zero,
    input logic a_neg,
    input logic q_zero,
    input logic q_neg,
    input logic [2:0] lever_key,
    // Jump and stop results
    output logic jump_take,
    output logic return_jump,
    output logic stop_req,
    // Input-output condition results
    output logic io_ext,
    output logic [iwd_pkg::CHAN_N-1:0] io_chan,
    output logic io_sense
);

    // ***************************************************************
    // Declarations
    // ***************************************************************
    iwd_pkg::iwd_state_t state;
    iwd_pkg::iwd_state_t next_state;
    logic [WORD_W-1:0] hold;
    logic lower_pending;
    logic [ADDR_W-1:0] acc;
    logic [2:0] key_m;
    logic [2:0] key_s;
    logic [iwd_pkg::INS_W-1:0] upper;
    logic [iwd_pkg::DES_W-1:0] des;
    logic [ADDR_W-1:0] base_addr;
    logic [1:0] tst;
    logic des_mod;
    logic lever_hit;
    logic reg_hit;

    iwd_xlat_if xb ();

    // ***************************************************************
    // Field split of the executing (upper) instruction
    // ***************************************************************
    assign upper = hold[WORD_W-1:iwd_pkg::UPPER_LSB]; // RULE_02
    assign xb.op = upper[iwd_pkg::INS_W-1:iwd_pkg::OP_LSB]; // RULE_01 RULE_06
    assign des = upper[iwd_pkg::OP_LSB-1:iwd_pkg::DES_LSB]; // RULE_01
    assign base_addr = upper[iwd_pkg::ADDR_LSB+ADDR_W-1:iwd_pkg::ADDR_LSB]; // RULE_20
    assign tst = des[1:0];
    assign des_mod = (des != iwd_pkg::DES_NONE) && (des != iwd_pkg::DES_INDIRECT);

    // Operation code translator
    iwd_opxlat u_xlat (
        .x(xb)
    );

    // Handshake and halt outputs straight from state; index select and operand address passed through
    assign word_req = (state == iwd_pkg::ST_FETCH); // RULE_21
    assign instr_valid = (state == iwd_pkg::ST_EXEC);
    assign idx_sel = des; // RULE_11
    assign operand_addr = acc; // RULE_04
    assign fault_halt = (state == iwd_pkg::ST_HALT); // RULE_05

    // ***************************************************************
    // Lever key synchroniser
    // ***************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            key_m <= 3'h0;
            key_s <= 3'h0;
        end
        else if (ce)
        begin
            key_m <= lever_key;
            key_s <= key_m;
        end
    end

    // ***************************************************************
    // Sequencer
    // ***************************************************************
    always_comb
    begin
        next_state = state;
        case (state)
            iwd_pkg::ST_FETCH:
                if (word_ack)
                    next_state = iwd_pkg::ST_COPY; // RULE_21
            iwd_pkg::ST_COPY:
                if (xb.grp.fault)
                    next_state = iwd_pkg::ST_HALT; // RULE_05
                else if (xb.grp.index_mod && des_mod)
                    next_state = iwd_pkg::ST_ADD; // RULE_11
                else
                    next_state = iwd_pkg::ST_EXEC; // RULE_12
            iwd_pkg::ST_ADD:
                next_state = iwd_pkg::ST_EXEC;
            iwd_pkg::ST_EXEC:
                if (exec_done)
                    next_state = lower_pending ? iwd_pkg::ST_SHIFT : iwd_pkg::ST_FETCH;
            iwd_pkg::ST_SHIFT:
                next_state = iwd_pkg::ST_COPY; // RULE_02
            iwd_pkg::ST_HALT:
                next_state = iwd_pkg::ST_HALT;
            default:
                next_state = iwd_pkg::ST_FETCH;
        endcase
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            state <= iwd_pkg::ST_FETCH;
        else if (ce)
            state <= next_state;
    end

    // ***************************************************************
    // Instruction holding rank
    // ***************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            hold <= iwd_pkg::WORD_RST;
            lower_pending <= 1'b0;
        end
        else if (ce)
        begin
            if (state == iwd_pkg::ST_FETCH && word_ack)
            begin
                hold <= word_data; // RULE_02 RULE_21
                lower_pending <= 1'b1;
            end
            else if (state == iwd_pkg::ST_SHIFT)
            begin
                hold <= {hold[iwd_pkg::INS_W-1:0], hold[iwd_pkg::INS_W-1:0]}; // RULE_02
                lower_pending <= 1'b0;
            end
        end
    end

    // ***************************************************************
    // Subtractive address accumulator
    // ***************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            acc <= iwd_pkg::ADDR_RST;
        else if (ce)
        begin
            if (state == iwd_pkg::ST_COPY)
                acc <= base_addr; // RULE_03 RULE_04
            else if (state == iwd_pkg::ST_ADD)
                acc <= iwd_pkg::iwd_sub_add(acc, idx_value); // RULE_03 RULE_04
        end
    end

    // Operand address qualifier
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            addr_valid <= 1'b0;
        else if (ce)
            addr_valid <= (next_state == iwd_pkg::ST_EXEC) && xb.grp.addr_opnd; // RULE_04
    end

    // ***************************************************************
    // Registered translation outputs
    // ***************************************************************
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            op_code <= iwd_pkg::OP_FAULT_LO;
            op_lo_hot <= 8'h00;
            op_hi_hot <= 8'h00;
            op_lo_grp <= 4'h0;
            op_grp <= iwd_pkg::GRP_RST;
        end
        else if (ce)
        begin
            op_code <= xb.op; // RULE_06
            op_lo_hot <= xb.lo_hot; // RULE_08
            op_hi_hot <= xb.hi_hot; // RULE_09
            op_lo_grp <= xb.lo_grp; // RULE_08
            op_grp <= xb.grp; // RULE_10
        end
    end

    // ***************************************************************
    // Designator interpretation
    // ***************************************************************
    always_comb
    begin
        lever_hit = (tst == iwd_pkg::TST_ZERO) || key_s[tst - 2'h1];
        reg_hit = 1'b0;
        case (tst)
            iwd_pkg::TST_ZERO:
                reg_hit = xb.grp.a_jump ? a_zero : q_zero;
            iwd_pkg::TST_NONZERO:
                reg_hit = xb.grp.a_jump ? !a_zero : !q_zero;
            iwd_pkg::TST_POS:
                reg_hit = xb.grp.a_jump ? !a_neg : !q_neg;
            iwd_pkg::TST_NEG:
                reg_hit = xb.grp.a_jump ? a_neg : q_neg;
            default:
                reg_hit = 1'b0;
        endcase
    end

    // Index usage flags
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            indirect <= 1'b0;
            idx_operand <= 1'b0;
            one_word <= 1'b0;
            nop <= 1'b0;
        end
        else if (ce)
        begin
            indirect <= (xb.grp.index_mod || xb.grp.idx_operand)
                        && des == iwd_pkg::DES_INDIRECT; // RULE_11 RULE_12
            idx_operand <= xb.grp.idx_operand && des_mod; // RULE_12
            one_word <= xb.grp.xfer_search && des == iwd_pkg::DES_NONE; // RULE_14
            nop <= xb.grp.op_nop && des == iwd_pkg::DES_NONE; // RULE_13
        end
    end

    // Jump and stop conditions
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            jump_take <= 1'b0;
            return_jump <= 1'b0;
            stop_req <= 1'b0;
        end
        else if (ce)
        begin
            jump_take <= ((xb.grp.a_jump || xb.grp.q_jump) && reg_hit) // RULE_15
                         || (xb.grp.sel_jump && lever_hit) // RULE_16
                         || xb.grp.sel_stop; // RULE_17
            return_jump <= (xb.grp.a_jump || xb.grp.q_jump || xb.grp.sel_jump
                            || xb.grp.sel_stop) && des[iwd_pkg::RET_BIT]; // RULE_15
            stop_req <= xb.grp.sel_stop && lever_hit; // RULE_17
        end
    end

    // Input-output condition selects
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            io_ext <= 1'b0;
            io_chan <= 6'h00;
            io_sense <= 1'b0;
        end
        else if (ce)
        begin
            io_ext <= xb.grp.io_cond && des == iwd_pkg::DES_NONE; // RULE_18
            for (int c = 0; c < iwd_pkg::CHAN_N; c++)
                io_chan[c] <= xb.grp.io_cond && des == 3'(c + 1); // RULE_18 RULE_19
            io_sense <= xb.grp.io_cond && des == iwd_pkg::DES_SENSE; // RULE_19
        end
    end

    // ***************************************************************
    // Checks
    // ***************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_word_in;
        state == iwd_pkg::ST_FETCH && word_ack && ce;
    endsequence

    sequence s_last_done;
        state == iwd_pkg::ST_EXEC && exec_done && !lower_pending && ce;
    endsequence

    AST_FETCH_LOADS: assert property (s_word_in |=> state == iwd_pkg::ST_COPY // RULE_21
        && hold == $past(word_data) && lower_pending)
        else $error("Fetched word not loaded");

    AST_REFETCH: assert property (s_last_done |=> word_req) // RULE_21
        else $error("No new word requested after lower half");

    AST_FAULT_HALTS: assert property (state == iwd_pkg::ST_COPY && ce // RULE_05
        && (xb.op == iwd_pkg::OP_FAULT_LO || xb.op == iwd_pkg::OP_FAULT_HI)
        |=> fault_halt ##1 fault_halt)
        else $error("Fault code did not halt");

    AST_LOWER_UP: assert property (state == iwd_pkg::ST_SHIFT && ce // RULE_02
        |=> upper == $past(hold[iwd_pkg::INS_W-1:0]) && !lower_pending)
        else $error("Lower instruction not moved up");

    AST_ADDR_COPY: assert property (state == iwd_pkg::ST_COPY && ce // RULE_03
        |=> acc == $past(base_addr))
        else $error("Address not copied to accumulator");

    AST_ADDR_ADD: assert property (state == iwd_pkg::ST_ADD && ce // RULE_04
        |=> acc == iwd_pkg::iwd_sub_add($past(acc), $past(idx_value)))
        else $error("Index sum wrong");

    AST_LO_ONEHOT: assert property (ce |=> $onehot(op_lo_hot) // RULE_08
        && op_lo_hot[op_code[iwd_pkg::DIG_W-1:0]])
        else $error("Lower digit decode not one-hot");

    AST_NOP: assert property (ce |=> nop == ($past(xb.op) == iwd_pkg::OP_NOP // RULE_13
        && $past(des) == iwd_pkg::DES_NONE))
        else $error("No-operation decode wrong");

    AST_STOP_JUMPS: assert property (ce && xb.grp.sel_stop |=> jump_take // RULE_17
        && stop_req == $past(lever_hit))
        else $error("Selective stop jump wrong");

    AST_IO_ONE: assert property (ce |=> $onehot0({io_ext, io_chan, io_sense})) // RULE_19
        else $error("More than one I/O select");

endmodule // iwd_decoder

// File: iwd_far_model.sv
// Far-side stand-in: storage word answers, index registers, execution units.
// Assumes the bench sets word and dly; word and done answers change on falling edges, index values follow idx_sel at once.
`timescale 1ns/1ns
module iwd_far_model (
    // Clock and bench controls
    input logic clk,
    input logic rst_n,
    input logic [47:0] word,
    input logic [1:0] dly,
    // Decoder side
    input logic word_req,
    output logic word_ack,
    output logic [47:0] word_data,
    input logic [2:0] idx_sel,
    output logic [14:0] idx_value,
    input logic instr_valid,
    output logic exec_done
);
    logic go;
    logic [1:0] wcnt = 2'h0;
    logic [1:0] ecnt = 2'h0;

    // Index six holds a negative one's complement value
    assign idx_value = (idx_sel == 3'h6) ? 15'h7FFE : {9'h000, idx_sel, 3'h0};

    initial
    begin
        word_ack = 1'b0;
        exec_done = 1'b0;
        word_data = 48'h000000000000;
    end

    // Word answer after dly cycles; released data toggles every cycle
    always @(negedge clk)
    begin
        go = rst_n && word_req && !word_ack;
        word_ack <= go && wcnt >= dly;
        wcnt <= (go && wcnt < dly) ? wcnt + 2'h1 : 2'h0;
        word_data <= (go && wcnt >= dly) ? word : ~word_data;
        exec_done <= instr_valid && !exec_done && ecnt >= dly;
        ecnt <= (instr_valid && !exec_done && ecnt < dly) ? ecnt + 2'h1 : 2'h0;
    end
endmodule // iwd_far_model

// File: iwd_decoder_bench.sv
// Self-checking bench for the instruction word decoder.
// Assumes the far-side model answers fetches and executions.
`timescale 1ns/1ns
module iwd_decoder_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic word_req, word_ack, instr_valid, exec_done, fault_halt, addr_valid, indirect;
    logic idx_operand, one_word, nop, jump_take, return_jump, stop_req, io_ext, io_sense;
    logic a_zero = 1'b0, a_neg = 1'b0, q_zero = 1'b0, q_neg = 1'b0;
    logic [2:0] lever_key = 3'h0, idx_sel;
    logic [1:0] dly = 2'h1;
    logic [3:0] op_lo_grp;
    logic [5:0] op_code, io_chan;
    logic [7:0] op_lo_hot, op_hi_hot;
    logic [14:0] idx_value, operand_addr;
    logic [47:0] word = 48'h000000000000, word_data;
    iwd_pkg::iwd_grp_t op_grp;
    int n_errors = 0, checks_done = 0;

    // Clock of 40 ns
    initial forever #20 clk = ~clk;

    iwd_decoder iwd_decoder_inst (.clk, .rst_n, .ce, .word_req, .word_ack, .word_data,
        .idx_sel, .idx_value, .instr_valid, .exec_done, .op_code, .op_lo_hot, .op_hi_hot,
        .op_lo_grp, .op_grp, .fault_halt, .operand_addr, .addr_valid, .indirect, .idx_operand,
        .one_word, .nop, .a_zero, .a_neg, .q_zero, .q_neg, .lever_key, .jump_take,
        .return_jump, .stop_req, .io_ext, .io_chan, .io_sense);
    iwd_far_model iwd_far_model_inst (.clk, .rst_n, .word, .dly, .word_req, .word_ack,
        .word_data, .idx_sel, .idx_value, .instr_valid, .exec_done);

    // Expected group record, fault first, operand address last
    function automatic logic [10:0] exp_grp(input logic [5:0] f);
        return {f == 6'h00 || f == 6'h3F,
            f inside {[6'h01:6'h11], [6'h14:6'h1B], [6'h1E:6'h27], [6'h38:6'h3B]},
            f inside {6'h1C, 6'h1D, [6'h28:6'h2F], [6'h32:6'h37]}, f inside {[6'h32:6'h37]},
            f == 6'h12, f == 6'h13, f == 6'h3C, f == 6'h3D, f == 6'h3E, f == 6'h28,
            f inside {[6'h0A:6'h1B], [6'h1E:6'h27], 6'h2A, 6'h2B, [6'h2D:6'h3B], 6'h3D, 6'h3E}};
    endfunction

    // Expected flags: valid, nop, one, idxop, ind, sense, chan, ext, stop, ret, jump
    function automatic logic [15:0] exp_flags(input logic [23:0] ins);
        logic [5:0] f;
        logic [2:0] d;
        logic z, ng, k, cnd;
        logic [10:0] g;
        logic [15:0] r;
        f = ins[23:18];
        d = ins[17:15];
        g = exp_grp(f);
        z = (f == 6'h12) ? a_zero : q_zero;
        ng = (f == 6'h12) ? a_neg : q_neg;
        k = |({lever_key, 1'b1} & (4'h1 << d[1:0]));
        cnd = d[1] ? (d[0] ? ng : !ng) : (d[0] ? !z : z);
        r = '0;
        r[15] = g[0];
        r[14] = g[1] && d == 3'h0;
        r[13] = g[7] && d == 3'h0;
        r[12] = g[8] && d != 3'h0 && d != 3'h7;
        r[11] = d == 3'h7 && (g[9] || g[8]);
        if (f == 6'h3C) r[10:3] = {d == 3'h7, 6'((7'h01 << d) >> 1), d == 3'h0};
        if (f == 6'h12 || f == 6'h13) r[1:0] = {d[2], cnd};
        if (f == 6'h3D) r[1:0] = {d[2], k};
        if (f == 6'h3E) r[2:0] = {k, d[2], 1'b1};
        return r;
    endfunction

    // Expected address: one's complement sum for index group, designator 1 to 6
    function automatic logic [14:0] exp_addr(input logic [23:0] ins);
        logic [15:0] s;
        logic [2:0] d;
        logic [10:0] g;
        d = ins[17:15];
        g = exp_grp(ins[23:18]);
        s = {1'b0, ins[14:0]} + ((d == 3'h6) ? 16'h7FFE : {10'h000, d, 3'h0});
        if (g[9] && d != 3'h0 && d != 3'h7)
            return s[14:0] + {14'h0000, s[15]};
        return ins[14:0];
    endfunction

    task automatic test_done();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("BAD %0t got %h exp %h", $time, got, exp);
            n_errors++;
        end
    endtask

    // Bounded wait for a level on one decoder output
    task automatic wait_lvl(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 60)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 60)
        begin
            n_errors++;
            test_done();
        end
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        chk({44'h0, word_req, fault_halt, instr_valid, |op_code}, 48'h8);
        rst_n = 1'b1;
    endtask

    // Check one instruction in its execute step, then let it finish
    task automatic run_half(input logic [23:0] ins);
        logic [2:0] l;
        l = ins[20:18];
        wait_lvl(instr_valid, 1'b1);
        chk({3'h0, idx_sel, op_lo_grp, op_code, op_hi_hot, op_lo_hot, addr_valid, nop, one_word,
            idx_operand, indirect, io_sense, io_chan, io_ext, stop_req, return_jump, jump_take},
            {3'h0, ins[17:15], l >= 3'h4, l >= 3'h2, l <= 3'h3, l <= 3'h1, ins[23:18],
            8'h01 << ins[23:21], 8'h01 << l, exp_flags(ins)});
        chk({37'h0, op_grp}, {37'h0, exp_grp(ins[23:18])});
        chk({33'h0, operand_addr}, {33'h0, exp_addr(ins)});
        wait_lvl(instr_valid, 1'b0);
    endtask

    task automatic run_word(input logic [23:0] hi, input logic [23:0] lo);
        wait_lvl(word_req, 1'b1);
        word = {hi, lo};
        run_half(hi);
        run_half(lo);
    endtask

    task automatic t_addr();
        run_word({6'h0A, 3'h2, 15'h0005}, {6'h0A, 3'h6, 15'h0005});
        run_word({6'h0A, 3'h0, 15'h7FF0}, {6'h0A, 3'h7, 15'h0003});
    endtask

    task automatic t_ops();
        dly = 2'h3;
        run_word({6'h28, 3'h0, 15'h1234}, {6'h32, 3'h0, 15'h0100});
        run_word({6'h1C, 3'h3, 15'h0001}, {6'h36, 3'h7, 15'h0002});
    endtask

    task automatic t_jumps();
        a_zero = 1'b1;
        q_neg = 1'b1;
        for (int j = 0; j < 8; j++)
            run_word({6'h12, 3'(j), 15'h0010}, {6'h13, 3'(j), 15'h0020});
    endtask

    task automatic t_sel();
        for (int k = 2; k < 8; k += 3)
        begin
            lever_key = 3'(k);
            run_word({6'h28, 18'h0}, {6'h28, 18'h0});
            for (int j = 0; j < 8; j++)
                run_word({6'h3D, 3'(j), 15'h0040}, {6'h3E, 3'(j), 15'h0041});
        end
    endtask

    task automatic t_io();
        for (int j = 0; j < 8; j += 2)
            run_word({6'h3C, 3'(j), 15'h0000}, {6'h3C, 3'(j + 1), 15'h0000});
    endtask

    task automatic t_fault(input logic [5:0] f);
        do_reset();
        word = {f, 42'h0};
        wait_lvl(fault_halt, 1'b1);
        repeat (5) @(negedge clk);
        chk({45'h0, fault_halt, op_grp.fault, instr_valid}, 48'h6);
    endtask

    // Main sequence
    initial
    begin
        do_reset();
        t_addr();
        t_ops();
        t_jumps();
        t_sel();
        t_io();
        t_fault(6'h00);
        t_fault(6'h3F);
        test_done();
    end
endmodule // iwd_decoder_bench
